// [rtl/vpsir_an_emul.sv]
// Emulated auto-negotiation: completion flag that settles after each restart
`include "vpsir_defs.svh"

module vpsir_an_emul (
    // Control and result
    vpsir_ctrl_if.an ctl
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    vpsir_pkg::vpsir_an_state_t state_reg;
    vpsir_pkg::vpsir_an_state_t state_next;
    logic [`VPSIR_AN_CNT_W-1:0] cnt_reg;
    logic [`VPSIR_AN_CNT_W-1:0] cnt_next;
    wire logic settle_end;

    // Settling ends on the last cycle of the emulated exchange
    assign settle_end = (cnt_reg == `VPSIR_AN_CNT_W'(`VPSIR_AN_SETTLE_CYC - 1));
    assign ctl.an_complete = (state_reg == vpsir_pkg::VPSIR_AN_DONE);

    // Next state; a restart always wins and clears the flag
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            vpsir_pkg::VPSIR_AN_SETTLE: begin
                // Time only runs while negotiation is enabled
                if (ctl.an_enable) begin
                    cnt_next = cnt_reg + `VPSIR_AN_CNT_W'(1);
                    if (settle_end) begin
                        state_next = vpsir_pkg::VPSIR_AN_DONE;
                    end
                end
            end
            vpsir_pkg::VPSIR_AN_DONE: begin
                cnt_next = '0;
            end
            default: begin
                state_next = vpsir_pkg::VPSIR_AN_SETTLE;
                cnt_next = '0;
            end
        endcase
        if (ctl.an_restart) begin
            state_next = vpsir_pkg::VPSIR_AN_SETTLE;
            cnt_next = '0;
        end
    end

    always_ff @(posedge ctl.clk or negedge ctl.arst_n) begin
        if (!ctl.arst_n) begin
            state_reg <= vpsir_pkg::VPSIR_AN_SETTLE;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

endmodule : vpsir_an_emul

// [rtl/vpsir_ctrl_if.sv]
// Internal carrier between the register front end and its two helpers
interface vpsir_ctrl_if (
    input wire logic clk,
    input wire logic arst_n
);
    logic an_restart;
    logic an_enable;
    logic an_complete;
    logic oui_wr;
    logic oui_clear;
    vpsir_pkg::vpsir_word_t oui_wdata;
    vpsir_pkg::vpsir_word_t oui_value;

    // Register front end
    modport regs (
        input clk, arst_n, an_complete, oui_value,
        output an_restart, an_enable, oui_wr, oui_clear, oui_wdata
    );
    // Negotiation emulation
    modport an (
        input clk, arst_n, an_restart, an_enable,
        output an_complete
    );
    // Identifier storage
    modport store (
        input clk, arst_n, oui_wr, oui_clear, oui_wdata,
        output oui_value
    );
endinterface : vpsir_ctrl_if

// [rtl/vpsir_defs.svh]
// Offsets, field positions, fixed values and timing counts of the emulated PHY registers
`ifndef VPSIR_DEFS_SVH
`define VPSIR_DEFS_SVH

// ----------------------------------------------------------------
// Memory-mapped offsets (byte addresses)
// ----------------------------------------------------------------
`define VPSIR_OFF_CTRL 9'h1c0
`define VPSIR_OFF_STATUS 9'h1c4
`define VPSIR_OFF_OUI_HIGH 9'h1c8
`define VPSIR_WIN_TOP 3'h7
`define VPSIR_WORD_LAST 4'h6
`define VPSIR_WORD_SPEC 4'hf

// ----------------------------------------------------------------
// Serial management indices
// ----------------------------------------------------------------
`define VPSIR_IDX_CTRL 5'h00
`define VPSIR_IDX_STATUS 5'h01
`define VPSIR_IDX_OUI_HIGH 5'h02
`define VPSIR_IDX_LAST 5'h06
`define VPSIR_IDX_SPEC 5'h1f

// ----------------------------------------------------------------
// Control word bits decoded here
// ----------------------------------------------------------------
`define VPSIR_CTRL_SOFT_RESET_BIT 15
`define VPSIR_CTRL_RENEG_BIT 9

// ----------------------------------------------------------------
// Status word: fixed abilities, bit 5 supplied by the negotiation emulation
// ----------------------------------------------------------------
`define VPSIR_STAT_AN_DONE_BIT 5
`define VPSIR_STAT_FIXED 16'h780d
`define VPSIR_STAT_FIXED_MASK 16'hffdf

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define VPSIR_CLK_PERIOD_NS 10
`define VPSIR_AN_SETTLE_NS 200
`define VPSIR_AN_SETTLE_CYC \
    ((`VPSIR_AN_SETTLE_NS + `VPSIR_CLK_PERIOD_NS - 1) / `VPSIR_CLK_PERIOD_NS)
`define VPSIR_AN_CNT_W 8

`endif

// [rtl/vpsir_oui_store.sv]
// Storage of the upper half of the emulated PHY identifier
module vpsir_oui_store #(
    // Reset value of the identifier half; the value is arbitrary
    parameter logic [15:0] OUI_HIGH_DEFAULT = 16'h2c4e
) (
    // Write and clear requests, stored value
    vpsir_ctrl_if.store ctl
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    vpsir_pkg::vpsir_word_t oui_reg;

    assign ctl.oui_value = oui_reg;

    // any value, zero too, is kept as written
    always_ff @(posedge ctl.clk or negedge ctl.arst_n) begin
        if (!ctl.arst_n) begin
            oui_reg <= OUI_HIGH_DEFAULT;
        end else if (ctl.oui_clear) begin
            oui_reg <= OUI_HIGH_DEFAULT;
        end else if (ctl.oui_wr) begin
            oui_reg <= ctl.oui_wdata;
        end
    end

endmodule : vpsir_oui_store

// [rtl/vpsir_pkg.sv]
// Types shared by the emulated PHY status and identifier logic
package vpsir_pkg;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef logic [4:0] vpsir_index_t;
    typedef logic [15:0] vpsir_word_t;

    // Negotiation emulation states
    typedef enum logic [1:0] {
        VPSIR_AN_SETTLE,
        VPSIR_AN_DONE
    } vpsir_an_state_t;

endpackage : vpsir_pkg

// [rtl/vpsir_regs.sv]
// Emulated PHY status and identifier-high registers on the memory and serial ports
`include "vpsir_defs.svh"

// Contract
// - status bits 15, 10 and 9 always read 0.
// - status bits 14 down to 11 always read 1.
// - status bit 8 always reads 0, no extended status register.
// - status bit 6 reads 0, preamble suppression not accepted.
// - negotiation-complete bit 5 clears on any reset, sets after emulated negotiation.
// - status bit 4, remote fault, always reads 0.
// - link-up bit 2 reads 1, jabber bit 1 reads 0.
// - status bit 3 and bit 0 both read 1.
// - serial port serves only indices 0 through 6.
// - words are 16 bits serially; memory bits 31:16 read 0, writes ignored.
// - identifier-high is a 16-bit read/write field at bits 15:0.
// - an all-zero identifier is stored and returned like any value.
// - status word sits at memory offset 1C4h and serial index 1.
// - identifier-high sits at memory offset 1C8h and serial index 2.
// - writing control bit 15 as 1 restores defaults; the request self-clears.
// - writing control bit 9 as 1 reruns the emulated negotiation.
module vpsir_regs #(
    // Reset value of the identifier half; the value is arbitrary
    parameter logic [15:0] OUI_HIGH_DEFAULT = 16'h2c4e
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Memory-mapped register port
    input wire logic [8:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_ack,
    // Serial management port, after frame decoding
    input wire logic [4:0] mii_index,
    input wire logic mii_rd,
    input wire logic mii_wr,
    input wire logic [15:0] mii_wdata,
    output logic [15:0] mii_rdata,
    output logic mii_ack,
    output logic mii_index_valid,
    // Negotiation control from the control word owner
    input wire logic negotiation_enable,
    // Pulses and the completion flag towards the rest of the emulated PHY
    output logic emulated_phy_soft_reset,
    output logic renegotiate_trigger,
    output logic negotiation_complete
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------

    // Memory byte address to register index; bit 5 of the result flags a hit
    function automatic logic [5:0] vpsir_mem_index(input logic [8:0] addr);
        logic [3:0] word;
        logic [5:0] res;
        word = addr[5:2];
        res = 6'h00;
        if (addr[8:6] == `VPSIR_WIN_TOP && addr[1:0] == 2'h0) begin
            if (word <= `VPSIR_WORD_LAST) begin
                res = {1'b1, 1'b0, word};
            end else if (word == `VPSIR_WORD_SPEC) begin
                res = {1'b1, `VPSIR_IDX_SPEC};
            end
        end
        return res;
    endfunction : vpsir_mem_index

    // Word returned for an index; words kept elsewhere read 0 here
    function automatic vpsir_pkg::vpsir_word_t vpsir_read_word(
        input vpsir_pkg::vpsir_index_t idx,
        input vpsir_pkg::vpsir_word_t status,
        input vpsir_pkg::vpsir_word_t oui
    );
        vpsir_pkg::vpsir_word_t res;
        res = 16'h0000;
        case (idx)
            `VPSIR_IDX_STATUS: begin
                res = status;
            end
            `VPSIR_IDX_OUI_HIGH: begin
                res = oui;
            end
            default: begin
                res = 16'h0000;
            end
        endcase
        return res;
    endfunction : vpsir_read_word

    // ----------------------------------------------------------------
    // Helper instances
    // ----------------------------------------------------------------
    vpsir_ctrl_if u_ctrl (
        .clk(clk),
        .arst_n(arst_n)
    );

    vpsir_an_emul u_an (
        .ctl(u_ctrl)
    );

    vpsir_oui_store #(
        .OUI_HIGH_DEFAULT(OUI_HIGH_DEFAULT)
    ) u_store (
        .ctl(u_ctrl)
    );

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire logic [5:0] mem_map;
    wire logic mem_hit;
    wire vpsir_pkg::vpsir_index_t mem_idx;
    wire logic mii_own;

    // The memory window holds indices 0 to 6 and 31
    assign mem_map = vpsir_mem_index(mem_addr);
    assign mem_hit = mem_map[5];
    assign mem_idx = mem_map[4:0];
    // serial indices above 6 are not served
    assign mii_own = (mii_index <= `VPSIR_IDX_LAST);

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    wire logic mem_wr_ctrl;
    wire logic mii_wr_ctrl;
    wire logic mem_wr_oui;
    wire logic mii_wr_oui;
    wire logic soft_reset_req;
    wire logic reneg_req;

    // Control word writes are seen here only for their two action bits
    assign mem_wr_ctrl = mem_wr && mem_hit && (mem_idx == `VPSIR_IDX_CTRL);
    assign mii_wr_ctrl = mii_wr && mii_own && (mii_index == `VPSIR_IDX_CTRL);
    assign mem_wr_oui = mem_wr && mem_hit && (mem_idx == `VPSIR_IDX_OUI_HIGH);
    assign mii_wr_oui = mii_wr && mii_own && (mii_index == `VPSIR_IDX_OUI_HIGH);
    assign soft_reset_req = (mem_wr_ctrl && mem_wdata[`VPSIR_CTRL_SOFT_RESET_BIT])
        || (mii_wr_ctrl && mii_wdata[`VPSIR_CTRL_SOFT_RESET_BIT]);
    assign reneg_req = (mem_wr_ctrl && mem_wdata[`VPSIR_CTRL_RENEG_BIT])
        || (mii_wr_ctrl && mii_wdata[`VPSIR_CTRL_RENEG_BIT]);

    // ----------------------------------------------------------------
    // Action pulses
    // ----------------------------------------------------------------
    logic soft_reset_reg;
    logic reneg_reg;

    // one-cycle pulse, so the request clears itself
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            soft_reset_reg <= 1'b0;
            reneg_reg <= 1'b0;
        end else begin
            soft_reset_reg <= soft_reset_req;
            reneg_reg <= reneg_req;
        end
    end

    assign emulated_phy_soft_reset = soft_reset_reg;
    assign renegotiate_trigger = reneg_reg;

    // ----------------------------------------------------------------
    // Helper control
    // ----------------------------------------------------------------

    assign u_ctrl.an_restart = soft_reset_reg || reneg_reg;
    assign u_ctrl.an_enable = negotiation_enable;
    assign u_ctrl.oui_clear = soft_reset_reg;
    // memory port wins if both ports write in the same cycle
    assign u_ctrl.oui_wr = mem_wr_oui || mii_wr_oui;
    assign u_ctrl.oui_wdata = mem_wr_oui ? mem_wdata[15:0] : mii_wdata;

    // ----------------------------------------------------------------
    // Status word
    // ----------------------------------------------------------------
    wire vpsir_pkg::vpsir_word_t status_word;

    // T4 and T2 bits fixed 0
    // negotiation ability and extended capability fixed 1
    // built from constants and the negotiation flag, so no write can reach it
    assign status_word = (`VPSIR_STAT_FIXED & `VPSIR_STAT_FIXED_MASK)
        | (16'(u_ctrl.an_complete) << `VPSIR_STAT_AN_DONE_BIT);

    assign negotiation_complete = u_ctrl.an_complete;

    // ----------------------------------------------------------------
    // Read data selection
    // ----------------------------------------------------------------
    wire vpsir_pkg::vpsir_word_t mem_word;
    wire vpsir_pkg::vpsir_word_t mii_word;

    // Unmapped or foreign addresses read 0 rather than stalling the bus
    assign mem_word = mem_hit ?
        vpsir_read_word(mem_idx, status_word, u_ctrl.oui_value) : 16'h0000;
    assign mii_word = mii_own ?
        vpsir_read_word(mii_index, status_word, u_ctrl.oui_value) : 16'h0000;

    // ----------------------------------------------------------------
    // Memory port answer
    // ----------------------------------------------------------------
    logic [31:0] mem_rdata_reg;
    logic mem_ack_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_rdata_reg <= 32'h0000_0000;
            mem_ack_reg <= 1'b0;
        end else begin
            mem_ack_reg <= mem_rd || mem_wr;
            if (mem_rd) begin
                mem_rdata_reg <= {16'h0000, mem_word};
            end
        end
    end

    assign mem_rdata = mem_rdata_reg;
    assign mem_ack = mem_ack_reg;

    // ----------------------------------------------------------------
    // Serial port answer
    // ----------------------------------------------------------------
    logic [15:0] mii_rdata_reg;
    logic mii_ack_reg;
    logic mii_valid_reg;

    // serial words are 16 bits wide
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mii_rdata_reg <= 16'h0000;
            mii_ack_reg <= 1'b0;
            mii_valid_reg <= 1'b0;
        end else begin
            mii_ack_reg <= mii_rd || mii_wr;
            if (mii_rd || mii_wr) begin
                mii_valid_reg <= mii_own;
            end
            if (mii_rd) begin
                mii_rdata_reg <= mii_word;
            end
        end
    end

    assign mii_rdata = mii_rdata_reg;
    assign mii_ack = mii_ack_reg;
    // Lets the frame decoder tell a served index from an absent one
    assign mii_index_valid = mii_valid_reg;

endmodule : vpsir_regs

// [testbench/tb.sv]
// Self-checking bench for the emulated PHY status and identifier registers
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
    $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] OUI_DEF = 16'h4d17; // arbitrary identifier default
    localparam logic [31:0] ST_BASE = 32'h0000780d; // abilities, link up, no done
    localparam logic [31:0] ST_DONE = 32'h0000782d;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [8:0] mem_addr = 9'h000;
    logic mem_rd = 1'b0;
    logic mem_wr = 1'b0;
    logic [31:0] mem_wdata = 32'h0;
    logic [31:0] mem_rdata;
    logic mem_ack, negotiation_enable = 1'b1;
    logic [4:0] mii_index;
    logic mii_rd, mii_wr, mii_ack, mii_index_valid;
    logic [15:0] mii_wdata, mii_rdata;
    logic soft_rst, reneg, an_done;
    int error_cnt = 0;
    int checks_done = 0;
    always #5 clk = ~clk;
    vpsir_regs #(.OUI_HIGH_DEFAULT(OUI_DEF)) i_dut (.clk(clk), .arst_n(arst_n),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mii_index(mii_index), .mii_rd(mii_rd),
        .mii_wr(mii_wr), .mii_wdata(mii_wdata), .mii_rdata(mii_rdata), .mii_ack(mii_ack),
        .mii_index_valid(mii_index_valid), .negotiation_enable(negotiation_enable),
        .emulated_phy_soft_reset(soft_rst), .renegotiate_trigger(reneg),
        .negotiation_complete(an_done));
    vpsir_mgmt_model i_mgmt (.clk(clk), .mii_index(mii_index), .mii_rd(mii_rd),
        .mii_wr(mii_wr), .mii_wdata(mii_wdata), .mii_rdata(mii_rdata), .mii_ack(mii_ack),
        .mii_index_valid(mii_index_valid));
    // -------------------------------------------------
    // Access tasks
    // -------------------------------------------------
    task automatic mem_acc(input logic wr, input logic [8:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(negedge clk);
        mem_addr = a;
        mem_wdata = wd;
        mem_rd = !wr;
        mem_wr = wr;
        @(negedge clk);
        `CHK(mem_ack, 1'b1)
        rd = mem_rdata;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_addr = ~a;
        mem_wdata = ~wd;
    endtask : mem_acc
    task automatic mrd(input logic [8:0] a, input logic [31:0] exp);
        logic [31:0] d;
        mem_acc(1'b0, a, 32'h0, d);
        `CHK(d, exp)
    endtask : mrd
    task automatic mwr(input logic [8:0] a, input logic [31:0] wd);
        logic [31:0] d;
        mem_acc(1'b1, a, wd, d);
    endtask : mwr
    task automatic sacc(input logic wr, input logic [4:0] idx, input logic [15:0] v,
        input logic expv);
        logic [15:0] d;
        logic vld, ok;
        i_mgmt.access(wr, idx, v, int'(idx[0]), d, vld, ok);
        `CHK(ok, 1'b1)
        `CHK(vld, expv)
        if (!wr) begin
            `CHK(d, v)
        end
    endtask : sacc
    task automatic close_out;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    // Watchdog cuts a hang short
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        close_out();
    end
    // -------------------------------------------------
    // Scenarios
    // -------------------------------------------------
    initial begin
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        mrd(9'h1c4, ST_BASE);
        mrd(9'h1c8, {16'h0, OUI_DEF});
        sacc(1'b0, 5'h02, OUI_DEF, 1'b1);
        repeat (30) @(negedge clk);
        mrd(9'h1c4, ST_DONE);
        sacc(1'b0, 5'h01, ST_DONE[15:0], 1'b1);
        // Status ignores writes on both ports
        mwr(9'h1c4, 32'hffffffff);
        sacc(1'b1, 5'h01, 16'h0000, 1'b1);
        mrd(9'h1c4, ST_DONE);
        // Identifier high: zero, serial write, upper half discarded
        mwr(9'h1c8, 32'h0);
        sacc(1'b0, 5'h02, 16'h0000, 1'b1);
        sacc(1'b1, 5'h02, 16'ha5c3, 1'b1);
        mrd(9'h1c8, 32'h0000a5c3);
        mwr(9'h1c8, 32'hffff5a3c);
        mrd(9'h1c8, 32'h00005a3c);
        // Unmapped memory word and serial indices around the top of the range
        mrd(9'h1e0, 32'h0);
        for (int i = 3; i < 9; i++) begin
            sacc(1'b0, 5'(i), 16'h0000, i < 7);
        end
        sacc(1'b0, 5'h1f, 16'h0000, 1'b0);
        // Renegotiate: flag drops then settles again
        mwr(9'h1c0, 32'h00001200);
        `CHK(reneg, 1'b1)
        `CHK(soft_rst, 1'b0)
        mrd(9'h1c4, ST_BASE);
        repeat (30) @(negedge clk);
        `CHK(an_done, 1'b1)
        // With negotiation disabled the flag stays clear
        negotiation_enable = 1'b0;
        sacc(1'b1, 5'h00, 16'h0200, 1'b1);
        repeat (30) @(negedge clk);
        `CHK(an_done, 1'b0)
        negotiation_enable = 1'b1;
        repeat (30) @(negedge clk);
        mrd(9'h1c4, ST_DONE);
        // Soft reset restores the identifier and clears the flag
        mwr(9'h1c8, 32'h00001234);
        mwr(9'h1c0, 32'h00008000);
        `CHK(soft_rst, 1'b1)
        mrd(9'h1c8, {16'h0, OUI_DEF});
        mrd(9'h1c4, ST_BASE);
        // Chip reset in mid-run
        mwr(9'h1c8, 32'h00000777);
        repeat (30) @(negedge clk);
        arst_n = 1'b0;
        @(negedge clk);
        `CHK(an_done, 1'b0)
        arst_n = 1'b1;
        mrd(9'h1c8, {16'h0, OUI_DEF});
        close_out();
    end
endmodule : tb

// [testbench/vpsir_chk.sv]
// Port checker for the emulated PHY status and identifier registers
module vpsir_chk #(
    parameter logic [15:0] OUI_HIGH_DEFAULT = 16'h2c4e
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Memory port
    input wire logic [8:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack,
    // Serial port
    input wire logic [4:0] mii_index,
    input wire logic mii_rd,
    input wire logic mii_wr,
    input wire logic [15:0] mii_wdata,
    input wire logic [15:0] mii_rdata,
    input wire logic mii_ack,
    input wire logic mii_index_valid,
    // Negotiation
    input wire logic negotiation_enable,
    input wire logic emulated_phy_soft_reset,
    input wire logic renegotiate_trigger,
    input wire logic negotiation_complete
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // -------------------------------------------------
    // Helper state
    // -------------------------------------------------
    logic [15:0] oui_reg;
    logic [7:0] an_cnt_reg;
    wire logic ctl_mem = mem_wr && mem_addr == 9'h1c0;
    wire logic ctl_mii = mii_wr && mii_index == 5'h00;
    wire logic restart = emulated_phy_soft_reset || renegotiate_trigger;
    // Shadow identifier; soft reset beats writes, memory write beats serial write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            oui_reg <= OUI_HIGH_DEFAULT;
        end else if (emulated_phy_soft_reset) begin
            oui_reg <= OUI_HIGH_DEFAULT;
        end else if (mem_wr && mem_addr == 9'h1c8) begin
            oui_reg <= mem_wdata[15:0];
        end else if (mii_wr && mii_index == 5'h02) begin
            oui_reg <= mii_wdata;
        end
    end
    // Enabled cycles since the last restart; saturates so it never wraps
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n || restart) begin
            an_cnt_reg <= 8'h00;
        end else if (negotiation_enable && an_cnt_reg != 8'hff) begin
            an_cnt_reg <= an_cnt_reg + 8'h01;
        end
    end
    // -------------------------------------------------
    // Assertions
    // -------------------------------------------------
    // fixed status bits
    a_stat_fixed: assert property (
        mem_rd && mem_addr == 9'h1c4 |=> (mem_rdata[15:0] & 16'hffdf) == 16'h780d)
        else $error("status fixed bits wrong");
    a_done_bit: assert property (
        mem_rd && mem_addr == 9'h1c4 |=> mem_rdata[5] == $past(negotiation_complete))
        else $error("status done bit wrong");
    a_stat_serial: assert property (
        mii_rd && mii_index == 5'h01 |=> mii_rdata == (16'h780d |
        {10'h000, $past(negotiation_complete), 5'h00})) else $error("serial status wrong");
    // four ability bits set over the serial port
    a_caps_serial: assert property (
        mii_rd && mii_index == 5'h01 |=> mii_rdata[14:11] == 4'hf)
        else $error("serial ability bits wrong");
    // link up and no jabber on the memory port
    a_link_jabber: assert property (
        mem_rd && mem_addr == 9'h1c4 |=> mem_rdata[2:1] == 2'h2)
        else $error("link or jabber bit wrong");
    a_upper_zero: assert property (mem_rdata[31:16] == 16'h0000)
        else $error("memory upper half not zero");
    a_index_valid: assert property (
        mii_rd || mii_wr |=> mii_ack && mii_index_valid == ($past(mii_index) <= 5'h06))
        else $error("serial ack or index flag wrong");
    a_oui_read: assert property (
        mem_rd && mem_addr == 9'h1c8 |=> mem_rdata[15:0] == $past(oui_reg))
        else $error("identifier memory read wrong");
    a_oui_serial: assert property (
        mii_rd && mii_index == 5'h02 |=> mii_rdata == $past(oui_reg))
        else $error("identifier serial read wrong");
    a_soft_pulse: assert property (
        (ctl_mem && mem_wdata[15]) || (ctl_mii && mii_wdata[15])
        |=> emulated_phy_soft_reset ##1 !negotiation_complete) else $error("soft reset lost");
    a_reneg_clear: assert property (
        (ctl_mem && mem_wdata[9]) || (ctl_mii && mii_wdata[9])
        |=> renegotiate_trigger ##1 !negotiation_complete [*8]) else $error("restart lost");
    a_an_settle: assert property (
        $rose(negotiation_complete) |-> an_cnt_reg >= 8'd18 && an_cnt_reg <= 8'd22)
        else $error("negotiation settle time wrong");
    c_stat_read: cover property (mem_rd && mem_addr == 9'h1c4);
    c_soft: cover property (emulated_phy_soft_reset);
    c_an_done: cover property ($rose(negotiation_complete));
endmodule : vpsir_chk

bind vpsir_regs vpsir_chk #(.OUI_HIGH_DEFAULT(OUI_HIGH_DEFAULT)) i_chk (
    .clk(clk), .arst_n(arst_n), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .mii_index(mii_index), .mii_rd(mii_rd), .mii_wr(mii_wr), .mii_wdata(mii_wdata),
    .mii_rdata(mii_rdata), .mii_ack(mii_ack), .mii_index_valid(mii_index_valid),
    .negotiation_enable(negotiation_enable), .emulated_phy_soft_reset(emulated_phy_soft_reset),
    .renegotiate_trigger(renegotiate_trigger), .negotiation_complete(negotiation_complete)
);

// [testbench/vpsir_mgmt_model.sv]
// Management master model driving the decoded serial port
module vpsir_mgmt_model (
    // Clock
    input wire logic clk,
    // Requests
    output logic [4:0] mii_index,
    output logic mii_rd,
    output logic mii_wr,
    output logic [15:0] mii_wdata,
    // Answers
    input wire logic [15:0] mii_rdata,
    input wire logic mii_ack,
    input wire logic mii_index_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        mii_index = 5'h1f;
        mii_rd = 1'b0;
        mii_wr = 1'b0;
        mii_wdata = 16'h0000;
    end
    // One access; gap idles first so slow masters are covered too
    task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
        input int gap, output logic [15:0] rd, output logic vld, output logic ok);
        repeat (gap + 1) @(negedge clk);
        mii_index = idx;
        mii_wdata = wd;
        mii_rd = !wr;
        mii_wr = wr;
        @(negedge clk);
        ok = mii_ack;
        rd = mii_rdata;
        vld = mii_index_valid;
        mii_rd = 1'b0;
        mii_wr = 1'b0;
        // Released lines show the inverse so stale values cannot pass
        mii_index = ~idx;
        mii_wdata = ~wd;
    endtask : access
endmodule : vpsir_mgmt_model
